// ===== design/gfc_dev.sv
`timescale 1ns/1ps
// Function
// RQ1 - Gate is a counted number of reference periods
// RQ2 - 10 MHz reference, internal or external
// RQ3 - Controller picks input and gate length
// RQ4 - Clear chain, then enable; no gate before
// RQ5 - Count input cycles in gate, then hold
// RQ6 - Controller reads count, converts to frequency
// RQ7 - Controller refreshes display with new result
// RQ8 - Gate length follows resolution setting
// RQ9 - Self test counts local oscillator signal
// RQ10 - Lamp test lights everything until exit
// RQ11 - Segment test steps one segment at rate
// RQ12 - Digit test steps whole digits
// RQ13 - Keypad test shows 05, then key position
// RQ14 - Function key or clear exits tests; keypad test ignores function keys, only clear exits it
// RQ15 - Resolution key blanks display quarter second
// RQ16 - Signed 1 Hz offset applied to results
// RQ17 - Offset indicators flash in entry, then steady; leaving entry by a function key keeps them flashing
// RQ18 - Recall plus clear-data erases offset
// RQ19 - Operator error codes 01, 02, 03
// RQ20 - Limit checks give codes 06, 07
// RQ21 - Checksum failure shows code 31 to 36
// RQ22 - Gate opens and closes on reference edges
module gfc_dev
   import gfc_pkg::*;
#(
   parameter int G1S = GATE_1S_REF,
   parameter int G100M = GATE_100M_REF,
   parameter int G10M = GATE_10M_REF,
   parameter int G1M = GATE_1M_REF,
   parameter int MS_CYC = MS_DIV
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Link to the controller
   gfc_if.dev lnk,
   // Signal and reference inputs
   input wire logic [3:0] sig_in,
   input wire logic lo_in,
   input wire logic ext_ref_in,
   input wire logic ext_ref_sel,
   // Front panel keys
   input wire logic key_stb,
   input wire logic [3:0] key_code,
   input wire logic [1:0] key_row,
   input wire logic [1:0] key_col,
   input wire logic fn_stb,
   input wire logic [2:0] fn_id,
   input wire logic [7:0] rate_ms,
   // Display
   output logic [31:0] disp_val_r,
   output logic disp_neg_r,
   output logic [7:0] disp_code_r,
   output logic code_mode_r,
   output logic blank_r,
   output logic [7:0] seg_r,
   output logic [7:0] dig_r,
   output logic frequency_indicator_r,
   output logic offset_indicator_r,
   output logic lamp_r
);
   typedef enum logic [1:0] {
      G_IDLE = 2'b00,
      G_ARM = 2'b01,
      G_OPEN = 2'b10,
      G_DONE = 2'b11
   } gfc_gate_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_BAND = 3'b001,
      S_RESOLUTION_SELECT_KEY = 3'b010,
      S_TEST1 = 3'b011,
      S_TEST2 = 3'b100,
      S_OFFSET = 3'b101,
      S_LIMIT = 3'b110
   } gfc_seq_t;

   logic int_tick, ms_tick, ext_q_r, sig_q_r, sig_src, ref_edge, sig_edge, is_dig;
   gfc_gate_t g_r;
   logic [31:0] refcnt_r, glen, cnt_r;
   gfc_seq_t seq_r;
   gfc_res_t res_r;
   logic [2:0] band_r;
   logic [3:0] test_r, tens_r;
   logic [31:0] acc_r, off_r, fdisp_r;
   logic typed_r, acc_neg_r, off_neg_r, off_act_r, edit_r, hi_sel_r;
   logic lo_set_r, hi_set_r, code_show_r, flash_r;
   logic [11:0] lim_lo_r, lim_hi_r;
   logic [7:0] code_r, blank_cnt_r, flash_cnt_r, step_ms_r;
   logic [5:0] step_r;
   logic [7:0] tnum;

   gfc_tick #(.DIV(REF_DIV)) u_ref (.mclk(mclk), .srst(srst), .tick_r(int_tick));
   gfc_tick #(.DIV(MS_CYC)) u_ms (.mclk(mclk), .srst(srst), .tick_r(ms_tick));

   // ---------------------------------------------------------------
   // Gate and count chain
   // ---------------------------------------------------------------
   assign ref_edge = ext_ref_sel ? (ext_ref_in && !ext_q_r) : int_tick; // RQ2
   assign sig_src = (test_r == TEST_200M) ? lo_in : sig_in[lnk.input_sel]; // RQ9
   assign sig_edge = sig_src && !sig_q_r;
   assign lnk.gate_done = (g_r == G_DONE);
   assign lnk.count = cnt_r;
   assign lnk.band = band_r;
   assign lnk.res = res_r;

   always_comb begin
      case (lnk.gate_sel)
         RES_1HZ: glen = 32'(G1S); // RQ8
         RES_10HZ: glen = 32'(G100M);
         RES_100HZ: glen = 32'(G10M);
         default: glen = 32'(G1M);
      endcase
   end

   always_ff @(posedge mclk) begin
      ext_q_r <= !srst && ext_ref_in;
      sig_q_r <= !srst && sig_src;
   end

   always_ff @(posedge mclk) begin
      if (srst || lnk.clr_chain) begin
         g_r <= G_IDLE;
         refcnt_r <= 32'h0;
      end else begin
         case (g_r)
            G_IDLE: if (lnk.gate_en) g_r <= G_ARM; // RQ4
            G_ARM: begin
               refcnt_r <= 32'h0;
               if (ref_edge) g_r <= G_OPEN; // RQ22
            end
            G_OPEN: begin
               if (ref_edge) begin
                  if (refcnt_r == glen - 32'h1) begin
                     g_r <= G_DONE; // RQ1 RQ22
                  end else begin
                     refcnt_r <= refcnt_r + 32'h1;
                  end
               end
            end
            G_DONE: g_r <= G_DONE;
            default: g_r <= G_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || lnk.clr_chain) begin
         cnt_r <= 32'h0; // RQ4
      end else if (g_r == G_OPEN && sig_edge) begin
         cnt_r <= cnt_r + 32'h1; // RQ5
      end
   end

   // ---------------------------------------------------------------
   // Key sequences; a lone keypress never crosses two states at once
   // ---------------------------------------------------------------
   assign is_dig = key_code <= 4'h9;
   assign tnum = 8'({tens_r, 3'b000}) + 8'({tens_r, 1'b0}) + 8'(key_code);

   always_ff @(posedge mclk) begin
      if (srst) begin
         seq_r <= S_IDLE;
         res_r <= RES_1HZ;
         band_r <= BAND_RST;
         test_r <= TEST_NONE;
         tens_r <= 4'h0;
         acc_r <= 32'h0;
         typed_r <= 1'b0;
         acc_neg_r <= 1'b0;
         off_r <= 32'h0;
         off_neg_r <= 1'b0;
         off_act_r <= 1'b0;
         edit_r <= 1'b0;
         hi_sel_r <= 1'b0;
         lim_lo_r <= 12'h0;
         lim_hi_r <= 12'h0;
         lo_set_r <= 1'b0;
         hi_set_r <= 1'b0;
         code_r <= 8'h0;
         code_show_r <= 1'b0;
         blank_cnt_r <= 8'h0;
      end else begin
         if (blank_cnt_r != 8'h0 && ms_tick) blank_cnt_r <= blank_cnt_r - 8'h1;
         if (lnk.csum_stb) begin
            code_r <= 8'(ERR_CSUM_BASE + {5'h0, lnk.csum_region}); // RQ21
            code_show_r <= 1'b1;
         end else if (fn_stb && test_r != TEST_KEY) begin
            test_r <= TEST_NONE; // RQ14
            code_show_r <= 1'b0;
            acc_r <= 32'h0;
            typed_r <= 1'b0;
            case (fn_id)
               FN_BAND: seq_r <= S_BAND;
               FN_RESOLUTION_SELECT_KEY: begin
                  seq_r <= S_RESOLUTION_SELECT_KEY;
                  blank_cnt_r <= BLANK_MS; // RQ15
               end
               FN_TEST: seq_r <= S_TEST1;
               FN_OFFSET: begin
                  seq_r <= S_OFFSET;
                  edit_r <= 1'b1; // RQ17
                  acc_r <= off_r;
                  acc_neg_r <= off_neg_r;
               end
               FN_LIM_LO, FN_LIM_HI: begin
                  seq_r <= S_LIMIT;
                  hi_sel_r <= (fn_id == FN_LIM_HI);
               end
               default: seq_r <= S_IDLE;
            endcase
         end else if (key_stb && key_code == KEY_CLR_DISP && seq_r != S_OFFSET) begin
            test_r <= TEST_NONE; // RQ14
            code_show_r <= 1'b0;
            seq_r <= S_IDLE;
         end else if (key_stb && test_r == TEST_KEY) begin
            code_r <= {2'b00, key_row, 2'b00, key_col}; // RQ13
         end else if (key_stb) begin
            seq_r <= S_IDLE;
            case (seq_r)
               S_BAND: begin
                  if (is_dig && key_code != 4'h0 && key_code <= BAND_MAX) begin
                     band_r <= 3'(key_code);
                  end else begin
                     code_r <= ERR_BAND; // RQ19
                     code_show_r <= 1'b1;
                  end
               end
               S_RESOLUTION_SELECT_KEY: begin
                  if (is_dig) begin
                     res_r <= (key_code > 4'h2) ? RES_COARSE : gfc_res_t'(key_code[1:0]); // RQ8
                  end else begin
                     code_r <= ERR_RES; // RQ19
                     code_show_r <= 1'b1;
                  end
               end
               S_TEST1: begin
                  tens_r <= key_code;
                  seq_r <= is_dig ? S_TEST2 : S_IDLE;
                  code_r <= ERR_SEQ;
                  code_show_r <= !is_dig;
               end
               S_TEST2: begin
                  if (is_dig && tnum != 8'h0 && tnum <= 8'(TEST_KEY)) begin
                     test_r <= 4'(tnum);
                     code_r <= KEYTEST_IDLE; // RQ13
                     code_show_r <= (4'(tnum) == TEST_KEY);
                  end else begin
                     code_r <= ERR_SEQ;
                     code_show_r <= 1'b1;
                  end
               end
               S_OFFSET: begin
                  seq_r <= S_OFFSET;
                  if (is_dig) begin
                     acc_r <= 32'((typed_r ? acc_r * 32'hA : 32'h0) + 32'(key_code));
                     typed_r <= 1'b1;
                  end else if (key_code == KEY_SIGN) begin
                     acc_neg_r <= !acc_neg_r;
                  end else if (key_code == KEY_UNITS) begin
                     off_r <= acc_r; // RQ16
                     off_neg_r <= acc_neg_r;
                     off_act_r <= 1'b1; // RQ17
                     edit_r <= 1'b0;
                     seq_r <= S_IDLE;
                  end else if (key_code == KEY_CLR_DATA) begin
                     off_r <= 32'h0; // RQ18
                     off_neg_r <= 1'b0;
                     off_act_r <= 1'b0;
                     edit_r <= 1'b0;
                     seq_r <= S_IDLE;
                  end else begin
                     edit_r <= 1'b0;
                     seq_r <= S_IDLE;
                  end
               end
               S_LIMIT: begin
                  seq_r <= S_LIMIT;
                  if (is_dig) begin
                     acc_r <= 32'(acc_r * 32'hA + 32'(key_code));
                  end else if (key_code == KEY_CLR_DATA) begin
                     lo_set_r <= lo_set_r && hi_sel_r;
                     hi_set_r <= hi_set_r && !hi_sel_r;
                     seq_r <= S_IDLE;
                  end else if (key_code == KEY_UNITS) begin
                     seq_r <= S_IDLE;
                     code_show_r <= 1'b1;
                     if (!hi_sel_r && acc_r[11:0] < LIM_LO_MIN_10M) begin
                        code_r <= ERR_LIM_LO; // RQ20
                     end else if (hi_sel_r && lo_set_r
                                  && acc_r[11:0] < lim_lo_r + LIM_GAP_10M) begin
                        code_r <= ERR_LIM_GAP; // RQ20
                     end else if (!hi_sel_r && hi_set_r
                                  && lim_hi_r < acc_r[11:0] + LIM_GAP_10M) begin
                        code_r <= ERR_LIM_GAP; // RQ20
                     end else begin
                        code_show_r <= 1'b0;
                        if (hi_sel_r) begin
                           lim_hi_r <= acc_r[11:0];
                           hi_set_r <= 1'b1;
                        end else begin
                           lim_lo_r <= acc_r[11:0];
                           lo_set_r <= 1'b1;
                        end
                     end
                  end else begin
                     seq_r <= S_IDLE;
                  end
               end
               default: begin
                  code_r <= ERR_SEQ; // RQ19
                  code_show_r <= 1'b1;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Offset applied to each new result
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         fdisp_r <= 32'h0;
      end else if (lnk.freq_stb) begin
         if (!off_act_r) fdisp_r <= lnk.freq_val;
         else if (off_neg_r) fdisp_r <= lnk.freq_val - off_r; // RQ16
         else fdisp_r <= lnk.freq_val + off_r; // RQ16
      end
   end

   // ---------------------------------------------------------------
   // Flash and test stepping timers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         flash_cnt_r <= 8'h0;
         flash_r <= 1'b0;
      end else if (ms_tick) begin
         flash_cnt_r <= (flash_cnt_r == FLASH_MS) ? 8'h0 : flash_cnt_r + 8'h1;
         if (flash_cnt_r == FLASH_MS) flash_r <= !flash_r;
      end
   end

   // Rate of zero would stall; treated as one step per ms
   always_ff @(posedge mclk) begin
      if (srst || (test_r != TEST_SEG && test_r != TEST_DIG)) begin
         step_ms_r <= 8'h0;
         step_r <= 6'h0;
      end else if (ms_tick) begin
         if (step_ms_r >= rate_ms) begin
            step_ms_r <= 8'h0;
            step_r <= step_r + ((test_r == TEST_SEG) ? 6'h01 : 6'h08); // RQ11 RQ12
         end else begin
            step_ms_r <= step_ms_r + 8'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Display drive
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         disp_val_r <= 32'h0;
         disp_neg_r <= 1'b0;
         disp_code_r <= 8'h0;
         code_mode_r <= 1'b0;
         blank_r <= 1'b0;
         seg_r <= 8'h0;
         dig_r <= 8'h0;
         frequency_indicator_r <= 1'b0;
         offset_indicator_r <= 1'b0;
         lamp_r <= 1'b0;
      end else begin
         disp_val_r <= (seq_r == S_OFFSET) ? acc_r : fdisp_r;
         disp_neg_r <= (seq_r == S_OFFSET) && acc_neg_r;
         disp_code_r <= code_r;
         code_mode_r <= code_show_r;
         blank_r <= (blank_cnt_r != 8'h0); // RQ15
         lamp_r <= (test_r == TEST_LED); // RQ10
         frequency_indicator_r <= (test_r == TEST_LED) || (edit_r ? flash_r : off_act_r); // RQ17
         offset_indicator_r <= (test_r == TEST_LED) || (edit_r ? flash_r : off_act_r);
         case (test_r)
            TEST_LED: begin
               seg_r <= 8'hFF; // RQ10
               dig_r <= 8'hFF;
            end
            TEST_SEG: begin
               seg_r <= 8'h01 << step_r[2:0]; // RQ11
               dig_r <= 8'h01 << step_r[5:3];
            end
            TEST_DIG: begin
               seg_r <= 8'hFF; // RQ12
               dig_r <= 8'h01 << step_r[5:3];
            end
            default: begin
               seg_r <= 8'h00;
               dig_r <= 8'h00;
            end
         endcase
      end
   end
endmodule

// ===== design/gfc_pkg.sv
package gfc_pkg;
   // ---------------------------------------------------------------
   // Clocks and times
   // ---------------------------------------------------------------
   localparam int MCLK_HZ = 100_000_000;
   localparam int REF_HZ = 10_000_000;
   localparam int REF_DIV = MCLK_HZ / REF_HZ;
   localparam int MS_DIV = MCLK_HZ / 1000;
   localparam int GATE_1S_MS = 1000;
   localparam int GATE_100M_MS = 100;
   localparam int GATE_10M_MS = 10;
   localparam int GATE_1M_MS = 1;
   localparam int GATE_1S_REF = GATE_1S_MS * (REF_HZ / 1000);
   localparam int GATE_100M_REF = GATE_100M_MS * (REF_HZ / 1000);
   localparam int GATE_10M_REF = GATE_10M_MS * (REF_HZ / 1000);
   localparam int GATE_1M_REF = GATE_1M_MS * (REF_HZ / 1000);
   localparam logic [7:0] BLANK_MS = 8'hFA;
   localparam logic [7:0] FLASH_MS = 8'hFA;

   // ---------------------------------------------------------------
   // Keys, functions, codes
   // ---------------------------------------------------------------
   localparam logic [3:0] KEY_SIGN = 4'hA;
   localparam logic [3:0] KEY_UNITS = 4'hB;
   localparam logic [3:0] KEY_CLR_DATA = 4'hC;
   localparam logic [3:0] KEY_CLR_DISP = 4'hD;
   localparam logic [2:0] FN_BAND = 3'h0;
   localparam logic [2:0] FN_RESOLUTION_SELECT_KEY = 3'h1;
   localparam logic [2:0] FN_TEST = 3'h2;
   localparam logic [2:0] FN_OFFSET = 3'h3;
   localparam logic [2:0] FN_LIM_LO = 3'h4;
   localparam logic [2:0] FN_LIM_HI = 3'h5;
   localparam logic [7:0] ERR_SEQ = 8'h01;
   localparam logic [7:0] ERR_RES = 8'h02;
   localparam logic [7:0] ERR_BAND = 8'h03;
   localparam logic [7:0] ERR_LIM_GAP = 8'h06;
   localparam logic [7:0] ERR_LIM_LO = 8'h07;
   localparam logic [7:0] ERR_CSUM_BASE = 8'h31;
   localparam logic [7:0] KEYTEST_IDLE = 8'h05;
   localparam logic [11:0] LIM_GAP_10M = 12'h00A;
   localparam logic [11:0] LIM_LO_MIN_10M = 12'h05F;
   localparam logic [3:0] BAND_MAX = 4'h4;
   localparam logic [3:0] TEST_NONE = 4'h0;
   localparam logic [3:0] TEST_200M = 4'h1;
   localparam logic [3:0] TEST_LED = 4'h2;
   localparam logic [3:0] TEST_SEG = 4'h3;
   localparam logic [3:0] TEST_DIG = 4'h4;
   localparam logic [3:0] TEST_KEY = 4'h5;
   localparam logic [2:0] BAND_RST = 3'h1;

   typedef enum logic [1:0] {
      RES_1HZ = 2'b00,
      RES_10HZ = 2'b01,
      RES_100HZ = 2'b10,
      RES_COARSE = 2'b11
   } gfc_res_t;
endpackage

// ===== design/gfc_if.sv
`timescale 1ns/1ps
interface gfc_if;
   import gfc_pkg::*;
   logic [1:0] input_sel;
   gfc_res_t gate_sel;
   logic clr_chain;
   logic gate_en;
   logic [31:0] freq_val;
   logic freq_stb;
   logic csum_stb;
   logic [2:0] csum_region;
   logic gate_done;
   logic [31:0] count;
   logic [2:0] band;
   gfc_res_t res;

   modport dev (
      input input_sel, gate_sel, clr_chain, gate_en, freq_val, freq_stb,
      input csum_stb, csum_region,
      output gate_done, count, band, res
   );
   modport host (
      output input_sel, gate_sel, clr_chain, gate_en, freq_val, freq_stb,
      output csum_stb, csum_region,
      input gate_done, count, band, res
   );
endinterface

// ===== design/gfc_tick.sv
`timescale 1ns/1ps
module gfc_tick #(
   parameter int DIV = 10
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Pulse out
   output logic tick_r
);
   logic [31:0] cnt_r;

   always_ff @(posedge mclk) begin
      if (srst || cnt_r == 32'(DIV - 1)) begin
         cnt_r <= 32'h0;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end

   always_ff @(posedge mclk) begin
      tick_r <= !srst && cnt_r == 32'(DIV - 1);
   end
endmodule

// ===== design/gfc_host.sv
`timescale 1ns/1ps
module gfc_host
   import gfc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Link to the counter
   gfc_if.host lnk,
   // Controller side
   input wire logic run,
   input wire logic csum_fail_stb,
   input wire logic [2:0] csum_fail_region,
   output logic meas_stb_r,
   output logic [31:0] meas_hz_r
);
   typedef enum logic [2:0] {
      H_CLR = 3'b000,
      H_ARM = 3'b001,
      H_WAIT = 3'b010,
      H_CALC = 3'b011,
      H_SHOW = 3'b100
   } gfc_hst_t;

   gfc_hst_t st_r;
   logic [1:0] sel_r;
   gfc_res_t gsel_r;
   logic clr_r;
   logic en_r;
   logic stb_r;
   logic [31:0] hz_r;
   logic [31:0] prod;

   assign lnk.input_sel = sel_r;
   assign lnk.gate_sel = gsel_r;
   assign lnk.clr_chain = clr_r;
   assign lnk.gate_en = en_r;
   assign lnk.freq_val = hz_r;
   assign lnk.freq_stb = stb_r;
   assign lnk.csum_stb = csum_fail_stb;
   assign lnk.csum_region = csum_fail_region;

   // ---------------------------------------------------------------
   // Count to hertz
   // ---------------------------------------------------------------
   always_comb begin
      case (gsel_r)
         RES_1HZ: prod = lnk.count; // RQ6
         RES_10HZ: prod = 32'(lnk.count * 32'hA);
         RES_100HZ: prod = 32'(lnk.count * 32'h64);
         default: prod = 32'(lnk.count * 32'h3E8);
      endcase
   end

   // ---------------------------------------------------------------
   // Measurement cycle
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_r <= H_CLR;
         sel_r <= 2'h0;
         gsel_r <= RES_1HZ;
         clr_r <= 1'b0;
         en_r <= 1'b0;
         stb_r <= 1'b0;
         hz_r <= 32'h0;
         meas_stb_r <= 1'b0;
         meas_hz_r <= 32'h0;
      end else begin
         stb_r <= 1'b0;
         meas_stb_r <= 1'b0;
         clr_r <= 1'b0;
         case (st_r)
            H_CLR: begin
               if (run) begin
                  sel_r <= 2'(lnk.band - 3'h1); // RQ3
                  gsel_r <= lnk.res; // RQ3
                  clr_r <= 1'b1; // RQ4
                  st_r <= H_ARM;
               end
            end
            H_ARM: begin
               en_r <= 1'b1; // RQ4
               st_r <= H_WAIT;
            end
            H_WAIT: begin
               if (lnk.gate_done) begin
                  en_r <= 1'b0;
                  st_r <= H_CALC;
               end
            end
            H_CALC: begin
               hz_r <= prod; // RQ6
               meas_hz_r <= prod;
               st_r <= H_SHOW;
            end
            H_SHOW: begin
               stb_r <= 1'b1; // RQ7
               meas_stb_r <= 1'b1;
               st_r <= H_CLR;
            end
            default: st_r <= H_CLR;
         endcase
      end
   end
endmodule

// ===== bench/gfc_checker.sv
`timescale 1ns/1ps
module gfc_checker (
   // Link signals
   input wire logic mclk,
   input wire logic srst,
   input wire logic clr_chain,
   input wire logic gate_en,
   input wire logic gate_done,
   input wire logic [31:0] count,
   input wire logic freq_stb,
   input wire logic [2:0] band
);
   // ----------------------------------------------
   // Link rules
   // ----------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   chk_clr_zero: assert property (clr_chain |=> count == 32'h0 && !gate_done)
      else $error("count not cleared");
   chk_en_after: assert property (clr_chain |=> gate_en)
      else $error("gate enable late");
   chk_no_open: assert property (!gate_en && !clr_chain && count == 32'h0 |=> count == 32'h0)
      else $error("count moved while disabled");
   chk_count_step: assert property (gate_en && !clr_chain |=>
      count == $past(count) || count == $past(count) + 32'h1) else $error("count step wrong");
   chk_done_hold: assert property (gate_done && !clr_chain |=> gate_done && $stable(count))
      else $error("held count changed");
   // Bound fits the longest gate of the bench's shortened parameters
   chk_gate_max: assert property ($rose(gate_en) |-> ##[1:450] gate_done)
      else $error("gate never closed");
   chk_gate_min: assert property ($rose(gate_en) |=> !gate_done [*8])
      else $error("gate too short");
   chk_stb_pulse: assert property (freq_stb |=> !freq_stb)
      else $error("result strobe too long");
   chk_stb_after: assert property (freq_stb |-> gate_done && !gate_en)
      else $error("result before gate end");
   chk_band_ok: assert property (band >= 3'h1 && band <= 3'h4)
      else $error("band out of range");
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import gfc_pkg::*;
   logic mclk, srst, run, csum_fail_stb, key_stb, fn_stb, meas_stb_r, code_mode_r;
   logic [2:0] csum_fail_region, fn_id;
   logic [3:0] key_code, sig_in, dv;
   logic [1:0] key_row, key_col;
   logic ext_ref_sel, disp_neg_r, blank_r, frequency_indicator_r, offset_indicator_r, lamp_r;
   logic [7:0] disp_code_r, last, seg_r, dig_r;
   logic [31:0] meas_hz_r, rnd, got, disp_val_r;
   logic [31:0] q[$];
   logic [31:0] exp_m [4] = '{32'h28, 32'hC8, 32'h3E8, 32'h1388};
   int err_count, comparisons;
   gfc_if lnk();
   gfc_host i_gfc_host(.mclk, .srst, .lnk(lnk), .run, .csum_fail_stb, .csum_fail_region,
      .meas_stb_r, .meas_hz_r);
   gfc_dev #(.G1S(40), .G100M(20), .G10M(10), .G1M(5), .MS_CYC(20)) i_gfc_dev(.mclk, .srst,
      .lnk(lnk), .sig_in, .lo_in(dv[0]), .ext_ref_in(dv[0]), .ext_ref_sel, .key_stb,
      .key_code, .key_row, .key_col, .fn_stb, .fn_id, .rate_ms(rnd[7:0]), .disp_val_r,
      .disp_neg_r, .disp_code_r, .code_mode_r, .blank_r, .seg_r, .dig_r,
      .frequency_indicator_r, .offset_indicator_r, .lamp_r);
   gfc_checker i_gfc_checker(.mclk, .srst, .clr_chain(lnk.clr_chain), .gate_en(lnk.gate_en),
      .gate_done(lnk.gate_done), .count(lnk.count), .freq_stb(lnk.freq_stb), .band(lnk.band));
   // ----------------------------------------------
   // Stimulus and checking
   // ----------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // One rising edge per ref period
   always @(posedge mclk) dv <= (dv == 4'h9) ? 4'h0 : dv + 4'h1;
   assign sig_in = {4{dv < 4'h5}};
   assign got = (meas_stb_r === 1'b1) ? meas_hz_r : {24'h0, disp_code_r};
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic close_out;
      if (q.size() != 0) err_count++;
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic note(input logic [7:0] c);
      q.push_back({24'h0, c});
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Kind 0 key, 1 function, 2 checksum failure
   task automatic press(input logic [1:0] k, input logic [3:0] c);
      @(posedge mclk);
      #1;
      key_stb = (k == 2'h0);
      fn_stb = (k == 2'h1);
      csum_fail_stb = (k == 2'h2);
      fn_id = c[2:0];
      key_code = c;
      @(posedge mclk);
      #1;
      {key_stb, fn_stb, csum_fail_stb} = 3'h0;
      repeat (4) @(posedge mclk);
      #1;
   endtask
   task automatic meas(input logic [31:0] e);
      q.push_back(e);
      @(posedge mclk);
      #1 run = 1'b1;
      @(posedge mclk);
      #1 run = 1'b0;
      repeat (600) @(posedge mclk);
   endtask
   // A held code counts once
   always @(negedge mclk) begin
      if (meas_stb_r === 1'b1 || (code_mode_r === 1'b1 && disp_code_r !== last)) begin
         chk(got, q.size() ? q[0] : ~got);
         if (q.size() != 0) q.delete(0);
      end
      last = (code_mode_r === 1'b1) ? disp_code_r : 8'hFF;
   end
   initial begin
      {srst, run, csum_fail_stb, key_stb, fn_stb, ext_ref_sel} = 6'h20;
      {csum_fail_region, fn_id, key_code, key_row, key_col} = 14'h0;
      dv = 4'h0;
      last = 8'hFF;
      rnd = 32'h8B4F;
      repeat (12) @(posedge mclk);
      #1 srst = 1'b0;
      meas(exp_m[0]);
      for (int i = 3; i >= 0; i--) begin
         press(2'h1, {1'b0, FN_RESOLUTION_SELECT_KEY});
         press(2'h0, 4'(i));
         meas(exp_m[i]);
      end
      #1 ext_ref_sel = 1'b1;
      meas(32'h8);
      #1 ext_ref_sel = 1'b0;
      press(2'h1, {1'b0, FN_OFFSET});
      press(2'h0, 4'h7);
      press(2'h0, KEY_UNITS);
      meas(exp_m[0]);
      #1 chk(disp_val_r, 32'h2F);
      chk({29'h0, disp_neg_r, frequency_indicator_r, offset_indicator_r}, 32'h3);
      press(2'h1, {1'b0, FN_OFFSET});
      press(2'h0, KEY_CLR_DATA);
      chk({29'h0, disp_neg_r, frequency_indicator_r, offset_indicator_r}, 32'h0);
      press(2'h1, {1'b0, FN_TEST});
      press(2'h0, 4'h0);
      press(2'h0, 4'h1);
      meas(exp_m[1]);
      note(ERR_SEQ);
      press(2'h0, 4'h5);
      note(ERR_BAND);
      press(2'h1, {1'b0, FN_BAND});
      press(2'h0, 4'h9);
      note(ERR_RES);
      press(2'h1, {1'b0, FN_RESOLUTION_SELECT_KEY});
      chk({31'h0, blank_r}, 32'h1);
      press(2'h0, KEY_SIGN);
      note(ERR_LIM_LO);
      press(2'h1, {1'b0, FN_LIM_LO});
      press(2'h0, 4'h5);
      press(2'h0, KEY_UNITS);
      press(2'h1, {1'b0, FN_TEST});
      press(2'h0, 4'h0);
      press(2'h0, 4'h2);
      chk({13'h0, lamp_r, frequency_indicator_r, offset_indicator_r, seg_r, dig_r}, 32'h7FFFF);
      note(ERR_BAND);
      press(2'h1, {1'b0, FN_BAND});
      press(2'h0, 4'h9);
      note(KEYTEST_IDLE);
      press(2'h1, {1'b0, FN_TEST});
      press(2'h0, 4'h0);
      press(2'h0, 4'h5);
      rnd = lfsr(rnd);
      key_row = rnd[1:0] | 2'h1;
      key_col = rnd[3:2];
      note({2'b00, key_row, 2'b00, key_col});
      press(2'h0, 4'h7);
      press(2'h0, KEY_CLR_DISP);
      rnd = lfsr(rnd);
      csum_fail_region = 3'(rnd % 32'h6);
      note(ERR_CSUM_BASE + {5'h0, csum_fail_region});
      press(2'h2, 4'h0);
      press(2'h0, KEY_CLR_DISP);
      close_out();
   end
   initial begin
      #200_000;
      err_count++;
      close_out();
   end
endmodule
